// File: hw/isc_pkg.sv
// Constants and carrier types of the start/stop condition control block
//
// Overview of operation
// RULE1 - Master select clear: follow remote master as slave
// RULE2 - Master select set: generate conditions and SCL
// RULE3 - Clear master select on loss, stop, reject
// RULE4 - Software checks busy, then writes start pattern
// RULE5 - Ignore master/direction write during duplicate window
// RULE6 - Duplicate window: busy rise to address received
// RULE7 - Start pattern write on free bus emits START
// RULE8 - After START, clear bit counter, clock byte
// RULE9 - START setup/hold: 20 standard, 10 fast
// RULE10 - Stop pattern write while enabled emits STOP
// RULE11 - STOP setup/hold: 20/18 standard, 12/10 fast
// RULE12 - Detect only when release, setup, hold met
// RULE13 - Busy set by START, cleared by STOP
// RULE14 - Standard thresholds: setting plus one, halved
// RULE15 - Fast thresholds: release 4, setup/hold 2
// RULE16 - Busy updates after delay; fast 3.5 cycles (the code uses ISC_BB_DLY_HS, 4 cycles)
// RULE17 - Never program setting zero or odd
// RULE18 - STOP seen as slave raises bus interrupt
// RULE19 - Busy forced low when disabled or reset
// RULE20 - Standard busy delay: setting minus one plus two
package isc_pkg;

  // Register byte addresses
  localparam logic [7:0] ISC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ISC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] ISC_ADDR_THRESH = 8'h08;
  localparam logic [7:0] ISC_ADDR_DATA   = 8'h0C;

  // Control register fields
  localparam int ISC_CTRL_EN = 0;
  localparam int ISC_CTRL_HS = 1;

  // Status register fields
  localparam int ISC_ST_MS   = 7;
  localparam int ISC_ST_TD   = 6;
  localparam int ISC_ST_BB   = 5;
  localparam int ISC_ST_WAIT = 4;
  localparam int ISC_ST_AL   = 3;

  // Reset value of the detection setting
  localparam logic [4:0] ISC_SSC_RST = 5'h18;

  // Generation counts in system clock cycles
  localparam logic [5:0] ISC_STA_SU_STD = 6'h14;
  localparam logic [5:0] ISC_STA_HD_STD = 6'h14;
  localparam logic [5:0] ISC_STA_SU_HS  = 6'h0A;
  localparam logic [5:0] ISC_STA_HD_HS  = 6'h0A;
  localparam logic [5:0] ISC_STO_SU_STD = 6'h14;
  localparam logic [5:0] ISC_STO_HD_STD = 6'h12;
  localparam logic [5:0] ISC_STO_SU_HS  = 6'h0C;
  localparam logic [5:0] ISC_STO_HD_HS  = 6'h0A;
  localparam logic [5:0] ISC_HALF_STD   = 6'h28;
  localparam logic [5:0] ISC_HALF_HS    = 6'h14;

  // Detection counts in system clock cycles
  localparam logic [5:0] ISC_DET_REL_HS = 6'h04;
  localparam logic [5:0] ISC_DET_SU_HS  = 6'h02;
  localparam logic [5:0] ISC_DET_HD_HS  = 6'h02;
  localparam logic [5:0] ISC_BB_DLY_HS  = 6'h04;
  localparam logic [5:0] ISC_REL_ADD    = 6'h01;
  localparam logic [5:0] ISC_BB_SUB     = 6'h01;
  localparam logic [5:0] ISC_BB_ADD     = 6'h02;

  // Bit counter: eight data bits then the acknowledge clock
  localparam logic [3:0] ISC_BIT_FIRST = 4'h0;
  localparam logic [3:0] ISC_BIT_ACK   = 4'h8;

  // Synchronised bus levels
  typedef struct packed {
    logic scl;
    logic sda;
  } isc_pins_t;

  // One-cycle condition events after the busy delay
  typedef struct packed {
    logic start;
    logic stop;
  } isc_det_t;

endpackage

// File: hw/isc_cond_detect.sv
// START/STOP condition detector with pin synchronisers
module isc_cond_detect
  import isc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  input  wire logic       enable,
  input  wire logic       high_speed,
  input  wire logic [4:0] ssc,
  output isc_pins_t       bus,
  output isc_det_t        det
);

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       sda_q;
  logic [5:0] scl_hi;
  logic [5:0] sda_st;
  logic [5:0] cnt;
  logic       pend;
  logic       held;
  logic       kind;
  logic [5:0] rel;
  logic [5:0] su;
  logic [5:0] bbd;
  logic       sda_edge;

  //////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_pin};
      sda_sync <= {sda_sync[0], sda_pin};
    end
  end

  assign bus = '{scl: scl_sync[1], sda: sda_sync[1]};

  // Thresholds per clock mode
  always_comb begin
    if (high_speed) begin
      rel = ISC_DET_REL_HS;                          // [RULE15]
      su  = ISC_DET_SU_HS;                           // [RULE15]
      bbd = ISC_BB_DLY_HS;                           // [RULE16]
    end else begin
      rel = {1'b0, ssc} + ISC_REL_ADD;               // [RULE14]
      su  = (rel + ISC_REL_ADD) >> 1;                // [RULE14]
      bbd = {1'b0, ssc} - ISC_BB_SUB + ISC_BB_ADD;   // [RULE20]
    end
  end

  assign sda_edge = bus.scl && (bus.sda != sda_q);

  //////////////////////////////////////////////////////////////////////////
  // Saturating high-time counters; half cycles rounded up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_q  <= 1'b1;
      scl_hi <= 6'h00;
      sda_st <= 6'h00;
    end else begin
      sda_q  <= bus.sda;
      scl_hi <= !bus.scl ? 6'h00 : scl_hi + {5'h00, scl_hi != 6'h3F};
      sda_st <= (!bus.scl || sda_edge) ? 6'h00
              : sda_st + {5'h00, sda_st != 6'h3F};
    end
  end

  // Qualify the edge, check hold, then report after the busy delay
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= 1'b0;
      held <= 1'b0;
      kind <= 1'b0;
      cnt  <= 6'h00;
      det  <= '0;
    end else begin
      det <= '0;
      if (!enable) begin
        pend <= 1'b0;
      end else if (sda_edge && scl_hi >= su && sda_st >= su) begin
        pend <= 1'b1;                                // [RULE12]
        held <= 1'b0;
        kind <= bus.sda;
        cnt  <= 6'h01;
      end else if (pend) begin
        cnt <= cnt + 6'h01;
        if (!held && (!bus.scl || bus.sda != kind)) begin
          pend <= 1'b0;                              // [RULE12]
        end else if (!held && cnt >= su) begin
          held <= scl_hi >= rel;                     // [RULE12]
          pend <= scl_hi >= rel;
        end else if (held && cnt >= bbd) begin
          pend      <= 1'b0;
          det.start <= !kind;                        // [RULE16]
          det.stop  <= kind;
        end
      end
    end
  end

endmodule

// File: hw/isc_start_stop_ctrl.sv
// START/STOP condition control with APB registers and byte clocking
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
module isc_start_stop_ctrl
  import isc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             serial_bus_irq
);

  typedef enum logic [3:0] {
    G_IDLE, G_STA_SU, G_STA_HD, G_LOW, G_HIGH,
    G_WAIT, G_STO_LOW, G_STO_SU, G_STO_HD
  } isc_gen_t;

  isc_gen_t   gen_state;
  logic [5:0] gen_cnt;
  logic       interface_enable;
  logic       high_speed;
  logic [4:0] detect_threshold_setting;
  logic       master_select;
  logic       transmit_direction;
  logic       bus_busy_flag;
  logic       byte_wait;
  logic       arb_lost;
  logic       addr_pending;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt;
  logic       scl_q;
  isc_pins_t  bus;
  isc_det_t   det;

  logic       acc;
  logic       wr_ctrl;
  logic       wr_st;
  logic       wr_thr;
  logic       wr_data;
  logic       mapped;
  logic       start_req;
  logic       stop_req;
  logic       dup_reject;
  logic       samp;
  logic       arb_now;
  logic       byte_end;
  logic       scl_rise;
  logic       slave_addr_done;
  logic       drive_low;
  logic [5:0] sta_su;
  logic [5:0] sta_hd;
  logic [5:0] sto_su;
  logic [5:0] sto_hd;
  logic [5:0] half;
  logic [31:0] next_rdata;

  //////////////////////////////////////////////////////////////////////////
  // Condition detector and pin synchronisers
  isc_cond_detect u_detect (
    .clk        (clk),
    .arst_n     (arst_n),
    .scl_pin    (scl_in),
    .sda_pin    (sda_in),
    .enable     (interface_enable),
    .high_speed (high_speed),
    .ssc        (detect_threshold_setting),
    .bus        (bus),
    .det        (det)
  );

  //////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, unmapped access flags an error
  assign acc     = psel && penable;
  assign mapped  = paddr == ISC_ADDR_CTRL || paddr == ISC_ADDR_STATUS ||
                   paddr == ISC_ADDR_THRESH || paddr == ISC_ADDR_DATA;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign wr_ctrl = acc && pwrite && paddr == ISC_ADDR_CTRL;
  assign wr_st   = acc && pwrite && paddr == ISC_ADDR_STATUS;
  assign wr_thr  = acc && pwrite && paddr == ISC_ADDR_THRESH;
  assign wr_data = acc && pwrite && paddr == ISC_ADDR_DATA;

  // Status write patterns
  assign start_req = wr_st && pwdata[ISC_ST_MS] && pwdata[ISC_ST_TD] &&
                     pwdata[ISC_ST_BB] && interface_enable &&
                     !bus_busy_flag && gen_state == G_IDLE;   // [RULE7]
  assign stop_req  = wr_st && pwdata[ISC_ST_MS] && pwdata[ISC_ST_TD] &&
                     !pwdata[ISC_ST_BB] && interface_enable &&
                     master_select && gen_state == G_WAIT;    // [RULE10]
  // Busy raised by another master inside the address window
  assign dup_reject = wr_st && pwdata[ISC_ST_MS] && bus_busy_flag &&
                      addr_pending && !master_select;         // [RULE5]

  // Read mux is sampled in the setup phase so prdata comes from a flop
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      ISC_ADDR_CTRL: begin
        next_rdata[ISC_CTRL_EN] = interface_enable;
        next_rdata[ISC_CTRL_HS] = high_speed;
      end
      ISC_ADDR_STATUS: begin
        next_rdata[ISC_ST_MS]   = master_select;
        next_rdata[ISC_ST_TD]   = transmit_direction;
        next_rdata[ISC_ST_BB]   = bus_busy_flag;
        next_rdata[ISC_ST_WAIT] = byte_wait;
        next_rdata[ISC_ST_AL]   = arb_lost;
      end
      ISC_ADDR_THRESH: next_rdata[4:0] = detect_threshold_setting;
      ISC_ADDR_DATA:   next_rdata[7:0] = shift_reg;
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_rdata;
    end
  end

  // Control and threshold registers; setting must be even, non-zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      interface_enable         <= 1'b0;
      high_speed               <= 1'b0;
      detect_threshold_setting <= ISC_SSC_RST;
    end else begin
      if (wr_ctrl) begin
        interface_enable <= pwdata[ISC_CTRL_EN];
        high_speed       <= pwdata[ISC_CTRL_HS];
      end
      if (wr_thr) begin
        detect_threshold_setting <= pwdata[4:0];      // [RULE17]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode-dependent generation counts
  assign sta_su = high_speed ? ISC_STA_SU_HS : ISC_STA_SU_STD;  // [RULE9]
  assign sta_hd = high_speed ? ISC_STA_HD_HS : ISC_STA_HD_STD;  // [RULE9]
  assign sto_su = high_speed ? ISC_STO_SU_HS : ISC_STO_SU_STD;  // [RULE11]
  assign sto_hd = high_speed ? ISC_STO_HD_HS : ISC_STO_HD_STD;  // [RULE11]
  assign half   = high_speed ? ISC_HALF_HS : ISC_HALF_STD;

  // Byte clocking events
  assign samp     = gen_state == G_HIGH && bus.scl && gen_cnt >= half;
  assign byte_end = samp && bit_cnt == ISC_BIT_ACK;
  assign arb_now  = samp && transmit_direction && bit_cnt < ISC_BIT_ACK &&
                    shift_reg[7] && !bus.sda;
  assign scl_rise = bus.scl && !scl_q;
  assign slave_addr_done = !master_select && scl_rise &&
                           bit_cnt == ISC_BIT_ACK;
  assign drive_low = transmit_direction && bit_cnt < ISC_BIT_ACK &&
                     !shift_reg[7];

  // Open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // Master generator: START, byte clocks, wait, STOP
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gen_state <= G_IDLE;
      gen_cnt   <= 6'h00;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (!interface_enable) begin
      gen_state <= G_IDLE;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
    end else begin
      gen_cnt <= gen_cnt + 6'h01;
      unique case (gen_state)
        G_IDLE: begin
          scl_oe  <= 1'b0;
          sda_oe  <= 1'b0;
          gen_cnt <= 6'h00;
          if (start_req) begin
            gen_state <= G_STA_SU;                    // [RULE2]
          end
        end
        G_STA_SU: begin
          // Setup counts only while both lines are seen released
          if (!bus.scl || !bus.sda) begin
            gen_cnt <= 6'h00;
          end else if (gen_cnt >= sta_su) begin
            sda_oe    <= 1'b1;                        // [RULE9]
            gen_cnt   <= 6'h01;  // Entry cycle counts toward the hold
            gen_state <= G_STA_HD;
          end
        end
        G_STA_HD: begin
          if (gen_cnt >= sta_hd) begin
            scl_oe    <= 1'b1;                        // [RULE9]
            gen_cnt   <= 6'h00;
            gen_state <= G_LOW;                       // [RULE8]
          end
        end
        G_LOW: begin
          sda_oe <= drive_low;
          if (gen_cnt >= half) begin
            scl_oe    <= 1'b0;
            gen_cnt   <= 6'h00;
            gen_state <= G_HIGH;
          end
        end
        G_HIGH: begin
          // A slave stretching SCL holds the count at zero
          if (!bus.scl) begin
            gen_cnt <= 6'h00;
          end else if (samp) begin
            gen_cnt <= 6'h00;
            if (arb_now) begin
              sda_oe <= 1'b0;
            end
            if (!byte_end) begin
              scl_oe    <= 1'b1;
              gen_state <= G_LOW;
            end else if (arb_lost || arb_now) begin
              scl_oe    <= 1'b0;
              sda_oe    <= 1'b0;
              gen_state <= G_IDLE;                    // [RULE3]
            end else begin
              scl_oe    <= 1'b1;
              sda_oe    <= 1'b0;
              gen_state <= G_WAIT;
            end
          end
        end
        G_WAIT: begin
          gen_cnt <= 6'h00;
          if (stop_req) begin
            gen_state <= G_STO_LOW;                   // [RULE10]
          end else if (wr_data) begin
            gen_state <= G_LOW;
          end
        end
        G_STO_LOW: begin
          sda_oe <= 1'b1;
          if (gen_cnt >= half) begin
            scl_oe    <= 1'b0;
            gen_cnt   <= 6'h00;
            gen_state <= G_STO_SU;
          end
        end
        G_STO_SU: begin
          if (!bus.scl) begin
            gen_cnt <= 6'h00;
          end else if (gen_cnt >= sto_su) begin
            sda_oe    <= 1'b0;                        // [RULE11]
            gen_cnt   <= 6'h00;
            gen_state <= G_STO_HD;
          end
        end
        G_STO_HD: begin
          if (gen_cnt >= sto_hd) begin
            gen_state <= G_IDLE;                      // [RULE11]
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bit counter: master clocks or remote clocks in slave mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= ISC_BIT_FIRST;
      scl_q   <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      if (gen_state == G_STA_HD || det.start) begin
        bit_cnt <= ISC_BIT_FIRST;                     // [RULE8]
      end else if (byte_end || slave_addr_done) begin
        bit_cnt <= ISC_BIT_FIRST;
      end else if (samp || (!master_select && scl_rise)) begin
        bit_cnt <= bit_cnt + 4'h1;                    // [RULE1]
      end
    end
  end

  // Shift register: software load, then shift on each sampled data bit, not on the acknowledge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 8'h00;
    end else if (wr_data) begin
      shift_reg <= pwdata[7:0];
    end else if (bit_cnt < ISC_BIT_ACK &&
                 (samp || (!master_select && scl_rise))) begin
      shift_reg <= {shift_reg[6:0], bus.sda};         // [RULE1]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Master select: set by the start pattern, cleared by hardware
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      master_select <= 1'b0;                          // [RULE3]
    end else if (start_req) begin
      master_select <= 1'b1;                          // [RULE4]
    end else if (det.stop || dup_reject ||
                 (byte_end && (arb_lost || arb_now))) begin
      master_select <= 1'b0;                          // [RULE3]
    end
  end

  // Direction: software writes, hardware clears on loss or conditions
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_direction <= 1'b0;
    end else if (start_req) begin
      transmit_direction <= 1'b1;
    end else if (arb_now || det.stop || dup_reject ||
                 (det.start && !master_select)) begin
      transmit_direction <= 1'b0;                     // [RULE5]
    end else if (wr_st && !pwdata[ISC_ST_MS]) begin
      transmit_direction <= pwdata[ISC_ST_TD];
    end
  end

  // Arbitration and end-of-byte wait flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arb_lost  <= 1'b0;
      byte_wait <= 1'b0;
    end else begin
      if (arb_now) begin
        arb_lost <= 1'b1;
      end else if (start_req) begin
        arb_lost <= 1'b0;
      end
      byte_wait <= gen_state == G_WAIT && !wr_data && !stop_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus busy from detected conditions, forced low while disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_busy_flag <= 1'b0;                          // [RULE19]
    end else if (!interface_enable) begin
      bus_busy_flag <= 1'b0;                          // [RULE19]
    end else if (det.start) begin
      bus_busy_flag <= 1'b1;                          // [RULE13]
    end else if (det.stop) begin
      bus_busy_flag <= 1'b0;                          // [RULE13]
    end
  end

  // Duplicate window: opens with busy, shuts when address is in
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_pending <= 1'b0;
    end else if (!interface_enable || det.stop) begin
      addr_pending <= 1'b0;
    end else if (det.start) begin
      addr_pending <= 1'b1;                           // [RULE6]
    end else if (byte_end || slave_addr_done) begin
      addr_pending <= 1'b0;                           // [RULE6]
    end
  end

  // Stop seen while a slave: one-cycle request to the CPU
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_bus_irq <= 1'b0;
    end else begin
      serial_bus_irq <= det.stop && !master_select;   // [RULE18]
    end
  end

endmodule

// File: testbench/isc_bus_peer.sv
// Remote master on the two-wire bus, making START and STOP frames
module isc_bus_peer (
  output logic scl_pull,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LINK = 64;

  // Released at time zero; the pull-ups hold the idle bus high
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // SDA falls under a long-high SCL, then SCL is held low
  task automatic start_cond;  // remote START
    sda_pull = 1'b1;
    #(2 * LINK);
    scl_pull = 1'b1;
    #(LINK);
  endtask

  // SCL released first, SDA later, so setup and hold both pass
  task automatic stop_cond;  // remote STOP
    sda_pull = 1'b1;
    #(LINK);
    scl_pull = 1'b0;
    #(2 * LINK);
    sda_pull = 1'b0;
    #(2 * LINK);
  endtask
endmodule

// File: testbench/isc_checker.sv
// Port checks for the start/stop condition control
module isc_checker
  import isc_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        scl_in,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_oe,
  input wire logic        serial_bus_irq
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       hs;
  logic       sda_prev;
  logic [5:0] hd_cnt;
  logic [5:0] su_cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  // Clock mode follows accepted control writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      hs <= 1'b0;
    else if (psel && penable && pwrite && paddr == ISC_ADDR_CTRL)
      hs <= pwdata[ISC_CTRL_HS];
  end

  // Counts only once SDA is pulled under released SCL, so the high
  // half of a data bit never looks like a start hold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_prev <= 1'b0;
      hd_cnt   <= 6'h00;
    end else begin
      sda_prev <= sda_oe;
      if (!sda_oe || scl_oe)
        hd_cnt <= 6'h00;
      else if (hd_cnt != 6'h00 || !sda_prev)
        hd_cnt <= hd_cnt + 6'h01;
    end
  end

  // Cycles of released SCL with SDA still pulled; saturates
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      su_cnt <= 6'h00;
    else if (!sda_oe || scl_oe)
      su_cnt <= 6'h00;
    else if (su_cnt != 6'h3F)
      su_cnt <= su_cnt + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_start;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence s_stop;
    $fell(sda_oe) && !scl_oe;
  endsequence

  a_irq_one_cycle: assert property (
    serial_bus_irq |=> !serial_bus_irq) else $error("irq too long");
  a_irq_bus_idle: assert property (
    serial_bus_irq |-> scl_in && sda_in) else $error("irq on busy bus");
  a_start_scl_high: assert property (
    s_start |-> scl_in) else $error("start with SCL low");
  a_start_hold: assert property (
    $rose(scl_oe) && hd_cnt != 6'h00 |->
      hd_cnt == (hs ? ISC_STA_HD_HS : ISC_STA_HD_STD))
    else $error("start hold wrong");
  a_stop_setup: assert property (
    s_stop |-> su_cnt >= (hs ? ISC_STO_SU_HS : ISC_STO_SU_STD))
    else $error("stop setup short");
  a_stop_hold: assert property (
    s_stop |=> !sda_oe [*8]) else $error("stop hold short");
  a_scl_low_half: assert property (
    $rose(scl_oe) |-> scl_oe [*8]) else $error("SCL low too short");
  a_data_stable: assert property (
    $fell(scl_oe) |-> $stable(sda_oe) [*8]) else $error("SDA moved");
endmodule

bind isc_start_stop_ctrl isc_checker u_chk (.clk, .arst_n, .paddr, .psel,
  .penable, .pwrite, .pwdata, .scl_in, .scl_oe, .sda_in, .sda_oe,
  .serial_bus_irq);

// File: testbench/isc_start_stop_ctrl_tb.sv
// Bench: APB master, remote bus master and open-drain wires
module isc_start_stop_ctrl_tb import isc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_out;
  logic        scl_oe;
  logic        sda_out;
  logic        sda_oe;
  logic        serial_bus_irq;
  logic        peer_scl;
  logic        peer_sda;
  logic        scl_w;
  logic        sda_w;
  logic        err;
  logic [8:0]  cap;
  int          n_scl;
  int          n_irq = 0;
  int          n_fail = 0;
  int          check_count = 0;
  int          seed = 64351;

  // Pull-ups: a line is low while any party pulls it
  assign scl_w = !(scl_oe && !scl_out) && !peer_scl;
  assign sda_w = !(sda_oe && !sda_out) && !peer_sda;

  always #2.5 clk = ~clk;

  isc_start_stop_ctrl u_dut (.clk, .arst_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .scl_in(scl_w),
    .scl_out, .scl_oe, .sda_in(sda_w), .sda_out, .sda_oe, .serial_bus_irq);
  isc_bus_peer u_peer (.scl_pull(peer_scl), .sda_pull(peer_sda));

  ////////////////////////////////////////////////////////////////////////
  // Bits on the wire at each SCL rise, and irq pulses
  always @(posedge scl_w) begin
    cap = {cap[7:0], sda_w};
    n_scl++;
  end
  always @(posedge clk) if (serial_bus_irq === 1'b1) n_irq++;

  task automatic final_report;
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string msg);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s", $time, msg);
      n_fail++;
    end
  endtask

  // One transfer: setup, then access held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] st(input logic ms, td, bb);
    return 32'({ms, td, bb}) << ISC_ST_BB;
  endfunction

  // Polls status; bounded so a stuck flag is reported, not hung on
  task automatic wait_st(input logic [31:0] m, v);
    logic [31:0] r;
    for (int i = 0; i < 4000; i++) begin
      apb(1'b0, ISC_ADDR_STATUS, 32'h0, r);
      if ((r & m) === v) break;
    end
    chk(r & m, v, "status wait");
  endtask

  initial begin
    #400us;
    n_fail++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [7:0]  d;
    int          k;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, ISC_ADDR_THRESH, 32'h0, r);
    chk(r, 32'(ISC_SSC_RST), "threshold reset");
    apb(1'b0, ISC_ADDR_STATUS, 32'h0, r);
    chk(r, 32'h0, "status reset"); // idle
    apb(1'b0, 8'h10, 32'h0, r);
    chk({r[30:0], err}, 32'h1, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      k = 2 * (({$random(seed)} % 15) + 1);
      apb(1'b1, ISC_ADDR_THRESH, 32'(k), r); // even setting
      apb(1'b1, ISC_ADDR_CTRL, 32'(i % 2 * 2 + 1), r);
      u_peer.start_cond();
      wait_st(32'hE0, st(0, 0, 1)); // busy set
      apb(1'b1, ISC_ADDR_STATUS, 32'hE0, r); // late start
      apb(1'b0, ISC_ADDR_STATUS, 32'h0, r);
      chk(r & 32'hE0, st(0, 0, 1), "dup start"); // reject
      k = n_irq;
      u_peer.stop_cond();
      wait_st(32'hE0, st(0, 0, 0)); // busy cleared
      chk(32'(n_irq - k), 32'h1, "slave stop irq"); // slave
      d = 8'($random(seed));
      apb(1'b1, ISC_ADDR_DATA, 32'(d), r);
      n_scl = 0;
      apb(1'b1, ISC_ADDR_STATUS, 32'hE0, r); // start
      wait_st(32'hF0, st(1, 1, 1) | (32'h1 << ISC_ST_WAIT));
      chk(32'(n_scl), 32'h9, "byte clocks"); // one byte
      chk(32'(cap[8:1]), 32'(d), "address bits"); // sent
      k = n_irq;
      apb(1'b1, ISC_ADDR_STATUS, 32'hC0, r); // stop
      wait_st(32'hA0, st(0, 0, 0)); // master dropped
      chk(32'(n_irq - k), 32'h0, "master stop irq"); // no irq
      u_peer.start_cond();
      wait_st(32'hE0, st(0, 0, 1));
      apb(1'b1, ISC_ADDR_CTRL, 32'h0, r);
      apb(1'b0, ISC_ADDR_STATUS, 32'h0, r);
      chk(r & 32'hE0, 32'h0, "busy while off"); // forced low
      u_peer.stop_cond();
    end
    final_report();
  end
endmodule
